/* src/sfr_bank_pkg.sv */
// package: register map constants for the bank-0/1 special-function register file
package sfr_bank_pkg;
  // --------------------------------------------------------------
  // register indices (data-memory file address)
  // --------------------------------------------------------------
  localparam logic [6:0] IDX_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] IDX_TIMER0 = 7'h01;
  localparam logic [6:0] IDX_PC_LOW = 7'h02;
  localparam logic [6:0] IDX_STATUS = 7'h03;
  localparam logic [6:0] IDX_POINTER = 7'h04;
  localparam logic [6:0] IDX_PORT_A = 7'h05;
  localparam logic [6:0] IDX_PORT_B = 7'h06;
  localparam logic [6:0] IDX_PORT_C = 7'h07;
  localparam logic [6:0] IDX_PC_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] IDX_INT_CONTROL = 7'h0B;
  localparam logic [6:0] IDX_PERIPH_FLAGS = 7'h0C;
  localparam logic [6:0] IDX_TIMER1_LOW = 7'h0E;
  localparam logic [6:0] IDX_TIMER1_HIGH = 7'h0F;
  localparam logic [6:0] IDX_TIMER1_CTRL = 7'h10;
  localparam logic [6:0] IDX_TIMER2 = 7'h11;
  localparam logic [6:0] IDX_TIMER2_CTRL = 7'h12;
  localparam logic [6:0] IDX_SERIAL_BUF = 7'h13;
  localparam logic [6:0] IDX_SERIAL_CTRL = 7'h14;
  localparam logic [6:0] IDX_CCP_LOW = 7'h15;
  localparam logic [6:0] IDX_CCP_HIGH = 7'h16;
  localparam logic [6:0] IDX_CCP_CTRL = 7'h17;
  localparam logic [6:0] IDX_ADC_RESULT = 7'h1E;
  localparam logic [6:0] IDX_ADC_CTRL = 7'h1F;
  // bank-1 serial status register, at the index of serial control in bank 0
  localparam logic [6:0] IDX_SERIAL_STATUS = 7'h14;
  // general-purpose RAM window in each bank
  localparam logic [6:0] IDX_GPR_FIRST = 7'h20;
  localparam logic [6:0] IDX_GPR_LAST = 7'h7F;
  // extra control/status words beyond the file
  localparam logic [11:0] ADDR_RESET_CAUSE = 12'h400;
  localparam logic [11:0] ADDR_PC_LOAD = 12'h404;
  localparam logic [11:0] ADDR_PC_VALUE = 12'h408;

  // --------------------------------------------------------------
  // field positions and masks
  // --------------------------------------------------------------
  localparam int STAT_IND_BANK = 7;
  localparam int STAT_UPPER_BANK = 6;
  localparam int STAT_LOWER_BANK = 5;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h18;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
  localparam logic [7:0] PORT_A_MASK = 8'h3F;
  localparam logic [7:0] PC_HIGH_MASK = 8'h1F;
  localparam logic [7:0] TIMER1_CONTROL_MASK = 8'h3F;
  localparam logic [7:0] TIMER2_CONTROL_MASK = 8'h7F;
  localparam logic [7:0] PIR_MASK = 8'h4F;
  localparam logic [7:0] CCPCON_MASK = 8'h3F;
  localparam logic [7:0] ADCON_MASK = 8'hFD;
  localparam logic [7:0] SSTAT_MASK = 8'h3F;
  localparam logic [7:0] INTERRUPT_CONTROL_KEEP_MASK = 8'h01;
  localparam logic [7:0] PORT_A_KEEP_MASK = 8'h10;
  localparam int STAT_TIMEOUT = 4;
  localparam int STAT_POWER_DOWN = 3;
  localparam int PC_HIGH_BITS = 5;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [12:0] PC_RESET = 13'h0000;

  // reset cause codes seen in the reset cause word at 0x400
  typedef enum logic [1:0] {CAUSE_POWER, CAUSE_BROWN_OUT, CAUSE_MASTER_CLEAR, CAUSE_WATCHDOG} reset_cause_e;
endpackage

/* src/core_sfr_bank.sv */
// module: bank-0/1 special-function register file reached over apb
//
// What this block does
// - file registers are plain flip-flop storage; the reset cause and pc bits 12 to 8 sit outside the data memory space.
// - core registers respond identically at the same offset in both banks.
// - program counter bits 12 to 8 are never a data-memory location.
// - 5-bit high latch is copied into pc bits 12 to 8 on load.
// - power-on/brown-out apply first reset column; other resets the second column.
// - master clear and watchdog resets are non-power-up resets.
// - serial status bits 7 and 6 always read zero.
// - unimplemented addresses and bits read zero and ignore writes.
// - status bits 6:5 select bank; 10 and 11 are unimplemented banks.
// - indirect port accesses the location addressed by the indirect pointer.
`timescale 1ns/1ps
`default_nettype none
module core_sfr_bank
  import sfr_bank_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic soft_reset_in,
  input wire logic [1:0] soft_reset_cause_in,
  input wire logic [PORT_WIDTH-1:0] port_a_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_b_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_c_pins_in,
  output logic [PORT_WIDTH-1:0] port_a_latch_out,
  output logic [PORT_WIDTH-1:0] port_b_latch_out,
  output logic [PORT_WIDTH-1:0] port_c_latch_out,
  output logic [12:0] prog_counter_out
);
  // ------------------------------------------------------------
  // operating notes
  // ------------------------------------------------------------
  // bus timing
  //   pready_out is tied high: every transfer is one setup cycle and
  //   one access cycle, with no wait state in between.
  //   a write lands on the access edge; read data is captured on the
  //   setup edge and stands on prdata_out until the next read setup.
  //   capturing on setup keeps the long decode path off the access
  //   edge, at the cost of a register stage on the read data.
  //   pslverr_out is tied low: holes and refused banks answer quietly.
  //   back-to-back transfers are fine; a read right behind a status or
  //   pointer write already decodes through the new bank and pointer.
  // address map
  //   file location n sits at byte address 4*n; only the low byte of
  //   each word carries data and the upper bytes read zero.
  //   byte addresses 0x000-0x1FC reach the file through the bank.
  //   0x400 returns the cause of the last reset in its two low bits.
  //   0x404 is write-only: it loads the counter from the high latch
  //   and the written byte in one step.
  //   0x408 returns the whole 13-bit counter for debug and test.
  //   any other address reads zero and ignores writes.
  // banks
  //   status bits 6:5 pick the bank of a direct access; patterns 10
  //   and 11 name banks that do not exist, so such reads return zero
  //   and such writes are dropped, core registers included.
  //   an indirect access takes bit 7 of the pointer as its bank bit
  //   and is refused while status bit 7 is set.
  //   bank 1 holds only its general-purpose window and the serial
  //   status register; its other slots read zero unless shared.
  //   the two general-purpose windows are separate storage, so a
  //   value parked in one bank never shows up in the other.
  //   an indirect access through a pointer at location 0 reads zero
  //   and writes nothing, so it cannot loop.
  // resets
  //   arst_n_in is the power-on and brown-out reset: every cell, those
  //   with an unknown start value included, comes up zero, status aside.
  //   soft_reset_in is the master clear or watchdog reset; it is
  //   sampled on the clock and one cycle of it is enough.
  //   while high it beats a bus write to any register that it resets;
  //   the general-purpose windows and timer1 control are left alone.
  //   soft_reset_cause_in is only looked at while soft_reset_in is
  //   high; it is kept at 0x400 and decides the timeout bit of status.
  // program counter
  //   software never writes counter bits 12:8 directly; it stages them
  //   in the high latch, and a load copies the latch across.
  //   a write to the low byte is such a load as well.
  //   reading the low byte returns the live counter, not a copy.
  // limitations
  //   pin reads lag the pins by two to three clocks because of the
  //   synchronisers; software polling a pin has to allow for that.
  //   nothing here increments the counter: the fetch logic that owns
  //   it sits outside this block.
  //   peripheral registers are plain storage; the timers, converter,
  //   serial port and capture unit that update them live elsewhere.
  //   the reserved bank bits are stored as written, so software that
  //   sets them by mistake can lock itself out until the next reset.

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] file_mem [0:IDX_GPR_LAST];
  logic [7:0] gpr_bank1 [IDX_GPR_FIRST:IDX_GPR_LAST];
  logic [7:0] serial_status;
  logic [1:0] last_cause;
  logic [12:0] prog_counter;
  logic [PORT_WIDTH-1:0] pa_meta, pa_sync, pb_meta, pb_sync, pc_meta, pc_sync;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // word index from byte address; low two bits ignored
  logic [9:0] word_idx;
  logic in_file;
  logic [1:0] bank_sel;
  logic [6:0] eff_idx;
  logic eff_bank1;
  logic eff_bank_bad;
  logic wr_fire;
  logic rd_fire;
  assign word_idx = paddr_in[11:2];
  assign in_file = (word_idx[9:7] == 3'b000);
  assign wr_fire = psel_in && penable_in && pwrite_in;
  assign rd_fire = psel_in && penable_in && !pwrite_in;

  // bank select bits
  // the reserved upper bit still takes part, so banks 2 and 3 are refused
  assign bank_sel = {file_mem[IDX_STATUS][STAT_UPPER_BANK], file_mem[IDX_STATUS][STAT_LOWER_BANK]};

  always_comb begin
    eff_idx = word_idx[6:0];
    eff_bank1 = (bank_sel == 2'b01);
    eff_bank_bad = bank_sel[1];
    if (word_idx[6:0] == IDX_INDIRECT_PORT) begin
      eff_idx = file_mem[IDX_POINTER][6:0];
      eff_bank1 = file_mem[IDX_POINTER][7];
      eff_bank_bad = file_mem[IDX_STATUS][STAT_IND_BANK];
    end
  end

  // core registers shared by both banks
  function automatic logic is_shared(input logic [6:0] idx);
    is_shared = (idx == IDX_PC_LOW) || (idx == IDX_STATUS) || (idx == IDX_POINTER) ||
                (idx == IDX_PC_HIGH_LATCH) || (idx == IDX_INT_CONTROL);
  endfunction

  // implemented-bit mask per bank-0 location, zero for holes
  function automatic logic [7:0] impl_mask(input logic [6:0] idx);
    case (idx)
      IDX_TIMER0, IDX_PC_LOW, IDX_STATUS, IDX_POINTER, IDX_PORT_B, IDX_PORT_C,
      IDX_INT_CONTROL, IDX_TIMER1_LOW, IDX_TIMER1_HIGH, IDX_TIMER2, IDX_SERIAL_BUF,
      IDX_SERIAL_CTRL, IDX_CCP_LOW, IDX_CCP_HIGH, IDX_ADC_RESULT: impl_mask = 8'hFF;
      IDX_PORT_A: impl_mask = PORT_A_MASK;
      IDX_PC_HIGH_LATCH: impl_mask = PC_HIGH_MASK;
      IDX_PERIPH_FLAGS: impl_mask = PIR_MASK;
      IDX_TIMER1_CTRL: impl_mask = TIMER1_CONTROL_MASK;
      IDX_TIMER2_CTRL: impl_mask = TIMER2_CONTROL_MASK;
      IDX_CCP_CTRL: impl_mask = CCPCON_MASK;
      IDX_ADC_CTRL: impl_mask = ADCON_MASK;
      default: impl_mask = is_gpr(idx) ? 8'hFF : ZERO_BYTE;
    endcase
  endfunction

  // general-purpose window test, shared by decode, write and read paths
  function automatic logic is_gpr(input logic [6:0] idx);
    is_gpr = (idx >= IDX_GPR_FIRST);
  endfunction

  // second reset column for one location, given its present content
  function automatic logic [7:0] other_reset_value(input logic [6:0] idx, input logic [7:0] cur,
    input logic [1:0] cause);
    case (idx)
      IDX_PC_LOW, IDX_PC_HIGH_LATCH, IDX_PERIPH_FLAGS, IDX_TIMER2, IDX_TIMER2_CTRL,
      IDX_SERIAL_CTRL, IDX_CCP_CTRL, IDX_ADC_CTRL: other_reset_value = ZERO_BYTE;
      IDX_INT_CONTROL: other_reset_value = cur & INTERRUPT_CONTROL_KEEP_MASK;
      IDX_PORT_A: other_reset_value = cur & PORT_A_KEEP_MASK;
      // timeout bit shows the cause, power-down bit set, flags unchanged
      IDX_STATUS: begin
        other_reset_value = cur & STATUS_KEEP_MASK;
        other_reset_value[STAT_TIMEOUT] = (cause != 2'(CAUSE_WATCHDOG));
        other_reset_value[STAT_POWER_DOWN] = 1'b1;
      end
      default: other_reset_value = cur;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // two stages; only the second is read
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pa_meta <= '0;
      pa_sync <= '0;
      pb_meta <= '0;
      pb_sync <= '0;
      pc_meta <= '0;
      pc_sync <= '0;
    end else begin
      pa_meta <= port_a_pins_in;
      pa_sync <= pa_meta;
      pb_meta <= port_b_pins_in;
      pb_sync <= pb_meta;
      pc_meta <= port_c_pins_in;
      pc_sync <= pc_meta;
    end
  end

  // ------------------------------------------------------------
  // register file writes
  // ------------------------------------------------------------
  // refused banks stop writes here, before any register sees them
  logic file_wr;
  assign file_wr = wr_fire && in_file && !eff_bank_bad;

  // bank-0 file plus shared core registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // power-on column; unknown cells come up zero
      for (int i = 0; i <= int'(IDX_GPR_LAST); i++) begin
        file_mem[i] <= ZERO_BYTE;
      end
      file_mem[IDX_STATUS] <= STATUS_POR_VALUE;
    end else if (soft_reset_in) begin
      // master clear or watchdog: second column for every location
      for (int i = 0; i <= int'(IDX_GPR_LAST); i++) begin
        file_mem[i] <= other_reset_value(7'(i), file_mem[i], soft_reset_cause_in);
      end
    end else if (file_wr && (is_shared(eff_idx) || !eff_bank1)) begin
      // holes and reserved bits dropped; no pc-high location exists
      file_mem[eff_idx] <= pwdata_in[7:0] & impl_mask(eff_idx);
    end
  end

  // bank-1 general-purpose RAM
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = int'(IDX_GPR_FIRST); i <= int'(IDX_GPR_LAST); i++) begin
        gpr_bank1[i] <= ZERO_BYTE;
      end
    end else if (file_wr && eff_bank1 && is_gpr(eff_idx)) begin
      gpr_bank1[eff_idx] <= pwdata_in[7:0];
    end
  end

  // serial status in bank 1, top two bits never stored
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_status <= ZERO_BYTE;
    end else if (soft_reset_in) begin
      serial_status <= ZERO_BYTE;
    end else if (file_wr && eff_bank1 && eff_idx == IDX_SERIAL_STATUS) begin
      serial_status <= pwdata_in[7:0] & SSTAT_MASK;
    end
  end

  // reset cause record for software
  // kept apart from status so software can tell master clear from power-on
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_cause <= 2'(CAUSE_POWER);
    end else if (soft_reset_in) begin
      last_cause <= soft_reset_cause_in;
    end
  end

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  // high bits only come from the latch on a load
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prog_counter <= PC_RESET;
    end else if (soft_reset_in) begin
      prog_counter <= PC_RESET;
    end else if (wr_fire && paddr_in == ADDR_PC_LOAD) begin
      prog_counter <= {file_mem[IDX_PC_HIGH_LATCH][PC_HIGH_BITS-1:0], pwdata_in[7:0]};
    end else if (file_wr && eff_idx == IDX_PC_LOW) begin
      prog_counter <= {file_mem[IDX_PC_HIGH_LATCH][PC_HIGH_BITS-1:0], pwdata_in[7:0]};
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [7:0] file_rd;
  always_comb begin
    file_rd = ZERO_BYTE;
    if (eff_bank_bad) begin
      file_rd = ZERO_BYTE;
    end else if (eff_bank1 && !is_shared(eff_idx)) begin
      if (eff_idx == IDX_SERIAL_STATUS) begin
        file_rd = serial_status & SSTAT_MASK;
      end else if (is_gpr(eff_idx)) begin
        file_rd = gpr_bank1[eff_idx];
      end
    end else begin
      case (eff_idx)
        IDX_PORT_A: file_rd = pa_sync[7:0] & PORT_A_MASK;
        IDX_PORT_B: file_rd = pb_sync[7:0];
        IDX_PORT_C: file_rd = pc_sync[7:0];
        IDX_PC_LOW: file_rd = prog_counter[7:0];
        default: file_rd = file_mem[eff_idx] & impl_mask(eff_idx);
      endcase
    end
  end

  // read data registered on the setup edge, shown through the access cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= ZERO_WORD;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      if (in_file) begin
        prdata_out <= {24'h000000, file_rd};
      end else if (paddr_in == ADDR_RESET_CAUSE) begin
        prdata_out <= {30'h0, last_cause};
      end else if (paddr_in == ADDR_PC_VALUE) begin
        prdata_out <= {19'h0, prog_counter};
      end else begin
        prdata_out <= ZERO_WORD;
      end
    end
  end

  // one access cycle, never an error
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  assign port_a_latch_out = file_mem[IDX_PORT_A][PORT_WIDTH-1:0];
  assign port_b_latch_out = file_mem[IDX_PORT_B][PORT_WIDTH-1:0];
  assign port_c_latch_out = file_mem[IDX_PORT_C][PORT_WIDTH-1:0];
  assign prog_counter_out = prog_counter;
endmodule
`default_nettype wire

/* tb/core_sfr_bank_props.sv */
// checker: bus, latch and program counter relations of the register file
`timescale 1ns/1ps
`default_nettype none
module core_sfr_bank_props #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic soft_reset_in,
  input wire logic [PORT_WIDTH-1:0] port_a_latch_out,
  input wire logic [PORT_WIDTH-1:0] port_b_latch_out,
  input wire logic [12:0] prog_counter_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // --------------------------------------------------------------
  // bank shadow, followed from status writes and cleared by soft reset
  // --------------------------------------------------------------
  logic [1:0] bank;
  // banks 2 and 3 drop status writes, so the shadow holds there
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bank <= 2'h0;
    end else if (soft_reset_in) begin
      bank <= 2'h0;
    end else if (psel_in && penable_in && pwrite_in && paddr_in == 12'h00C && !bank[1]) begin
      bank <= pwdata_in[6:5];
    end
  end
  sequence s_wr(logic [11:0] a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  sequence s_rd_setup(logic [11:0] a);
    psel_in && !penable_in && !pwrite_in && paddr_in == a;
  endsequence
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  property p_ready; psel_in && penable_in |-> pready_out && !pslverr_out; endproperty
  property p_upper_zero;
    psel_in && penable_in && !pwrite_in
      |-> prdata_out[31:13] == 19'h0 && (paddr_in[11:9] != 3'h0 || prdata_out[12:8] == 5'h0);
  endproperty
  property p_unimpl_read;
    psel_in && !penable_in && !pwrite_in && (paddr_in inside {12'h020, 12'h024, 12'h034, [12'h060:12'h074]})
      |=> prdata_out == 32'h0;
  endproperty
  property p_sstat; s_rd_setup(12'h050) ##0 (bank == 2'h1) |=> prdata_out[7:6] == 2'h0; endproperty
  property p_latch_b; s_wr(12'h018) ##0 (bank == 2'h0) |=> port_b_latch_out == $past(pwdata_in[7:0]); endproperty
  property p_pc_low; s_wr(12'h404) |=> prog_counter_out[7:0] == $past(pwdata_in[7:0]); endproperty
  property p_pc_hold;
    !soft_reset_in && !(psel_in && penable_in && pwrite_in && (paddr_in == 12'h404 || paddr_in == 12'h008))
      |=> $stable(prog_counter_out[12:8]);
  endproperty
  property p_soft_a; soft_reset_in |=> port_a_latch_out == ($past(port_a_latch_out) & 8'h10); endproperty
  property p_soft_b; soft_reset_in && !psel_in |=> $stable(port_b_latch_out); endproperty
  a_ready: assert property (p_ready) else $error("transfer not ready or flagged as error");
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero");
  a_unimpl_read: assert property (p_unimpl_read) else $error("unimplemented address read nonzero");
  a_sstat: assert property (p_sstat) else $error("serial status top bits not zero");
  a_latch_b: assert property (p_latch_b) else $error("port b latch missed write");
  a_pc_low: assert property (p_pc_low) else $error("pc low byte not loaded");
  a_pc_hold: assert property (p_pc_hold) else $error("pc upper bits moved without a load");
  a_soft_a: assert property (p_soft_a) else $error("port a latch wrong after soft reset");
  a_soft_b: assert property (p_soft_b) else $error("port b latch changed by soft reset");
endmodule
bind core_sfr_bank core_sfr_bank_props #(.PORT_WIDTH(PORT_WIDTH)) core_sfr_bank_props_i (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .soft_reset_in(soft_reset_in), .port_a_latch_out(port_a_latch_out),
  .port_b_latch_out(port_b_latch_out), .prog_counter_out(prog_counter_out));
`default_nettype wire

/* tb/tb_top.sv */
// testbench: apb register tests of the special-function register file
`timescale 1ns/1ps
`default_nettype none
module tb_top import sfr_bank_pkg::*;;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic soft_reset_in = 1'b0;
  logic [1:0] soft_reset_cause_in = 2'h0;
  logic [7:0] port_a_pins_in = 8'h00;
  logic [7:0] port_b_pins_in = 8'h00;
  logic [7:0] port_c_pins_in = 8'h00;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out;
  logic [7:0] port_a_latch_out, port_b_latch_out, port_c_latch_out;
  logic [12:0] prog_counter_out;
  int bad_count = 0;
  int comparisons = 0;
  logic [11:0] zero_regs [10] = '{12'h000, 12'h008, 12'h028, 12'h02C, 12'h030, 12'h040, 12'h044, 12'h048,
    12'h050, 12'h07C};
  logic [11:0] m_addr [16] = '{12'h020, 12'h024, 12'h034, 12'h060, 12'h064, 12'h068, 12'h06C, 12'h070,
    12'h074, 12'h500, 12'h028, 12'h030, 12'h040, 12'h048, 12'h05C, 12'h07C};
  logic [7:0] m_val [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h1F, 8'h4F, 8'h3F, 8'h7F, 8'h3F, 8'hFD};
  core_sfr_bank core_sfr_bank_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .soft_reset_in(soft_reset_in),
    .soft_reset_cause_in(soft_reset_cause_in), .port_a_pins_in(port_a_pins_in), .port_b_pins_in(port_b_pins_in),
    .port_c_pins_in(port_c_pins_in), .port_a_latch_out(port_a_latch_out), .port_b_latch_out(port_b_latch_out),
    .port_c_latch_out(port_c_latch_out), .prog_counter_out(prog_counter_out));
  // 250 MHz core clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // --------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one idle edge before each setup keeps strobes from being driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    tally_and_finish();
  end
  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    foreach (zero_regs[i]) rdc("reset value", zero_regs[i], 32'h0);
    rdc("status reset", 12'h00C, 32'h18);
    rdc("reset cause", ADDR_RESET_CAUSE, 32'h0);
    foreach (m_addr[i]) begin
      wr(m_addr[i], 32'hFFFF_FFFF);
      rdc("masked bits", m_addr[i], {24'h0, m_val[i]});
    end
    @(posedge clk_in);
    port_a_pins_in <= 8'hFF;
    port_b_pins_in <= 8'hA5;
    port_c_pins_in <= 8'h5A;
    wr(12'h014, 32'h35);
    wr(12'h018, 32'h3C);
    wr(12'h01C, 32'hC3);
    chk("latch a", 32'h35, {24'h0, port_a_latch_out});
    chk("latch b", 32'h3C, {24'h0, port_b_latch_out});
    chk("latch c", 32'hC3, {24'h0, port_c_latch_out});
    rdc("pins a", 12'h014, {24'h0, 8'hFF & PORT_A_MASK});
    rdc("pins b", 12'h018, 32'hA5);
    rdc("pins c", 12'h01C, 32'h5A);
    wr(12'h028, 32'h15);
    wr(ADDR_PC_LOAD, 32'hAB);
    chk("pc", 32'h15AB, {19'h0, prog_counter_out});
    rdc("pc value", ADDR_PC_VALUE, 32'h15AB);
    rdc("pc low", 12'h008, 32'hAB);
    wr(12'h008, 32'h12);
    chk("pc after low write", 32'h1512, {19'h0, prog_counter_out});
    wr(12'h00C, 32'h05);
    wr(12'h010, 32'h20);
    wr(12'h000, 32'h77);
    rdc("indirect write", 12'h080, 32'h77);
    wr(12'h00C, 32'h25);
    wr(12'h080, 32'h5A);
    wr(12'h050, 32'hFF);
    rdc("serial status", 12'h050, 32'h3F);
    rdc("pointer mirror", 12'h010, 32'h20);
    wr(12'h018, 32'h99);
    chk("latch b bank1", 32'h3C, {24'h0, port_b_latch_out});
    wr(12'h00C, 32'h05);
    rdc("gpr bank0", 12'h080, 32'h77);
    wr(12'h010, 32'hA0);
    rdc("indirect bank1", 12'h000, 32'h5A);
    for (int c = 2; c < 4; c++) begin
      wr(12'h028, 32'h15);
      @(posedge clk_in);
      soft_reset_in <= 1'b1;
      soft_reset_cause_in <= c[1:0];
      @(posedge clk_in);
      soft_reset_in <= 1'b0;
      #1;
      chk("latch a soft", 32'h10, {24'h0, port_a_latch_out});
      chk("latch b soft", 32'h3C, {24'h0, port_b_latch_out});
      rdc("status soft", 12'h00C, (c == 3) ? 32'h0D : 32'h1D);
      rdc("latch high soft", 12'h028, 32'h0);
      rdc("pointer soft", 12'h010, 32'hA0);
      rdc("cause soft", ADDR_RESET_CAUSE, 32'(c));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
